// file: irq_pkg.sv
// Constants shared by the external interrupt request logic
package irq_pkg;
  localparam int unsigned NUM_SRC      = 12;  // Interrupt sources
  localparam int unsigned NUM_PIN      = 6;   // External request pins a..f
  localparam int unsigned NUM_HWC      = 4;   // Hardware-clear selects c..f
  localparam int unsigned MC_CLKS      = 4;   // Clocks per machine cycle
  localparam int unsigned SRC_W        = 4;   // Width of a source index
  localparam int unsigned VEC_W        = 16;  // Vector address width
  // Source slots of the external pins
  localparam int unsigned SRC_EXT_A    = 0;
  localparam int unsigned SRC_EXT_B    = 2;
  localparam int unsigned SRC_EXT_C    = 7;
  // Pin positions inside the sampler bundle
  localparam int unsigned PIN_A        = 0;
  localparam int unsigned PIN_B        = 1;
  localparam int unsigned PIN_C        = 2;
  // Slots fed by pins; all others are peripheral sources
  localparam logic [11:0] EXT_MASK     = 12'h0785;
  localparam logic [11:0] FLAG_RESET   = 12'h0000;
  // Vector address = base + slot * step
  localparam logic [15:0] VEC_BASE     = 16'h0003;
  localparam logic [15:0] VEC_STEP     = 16'h0008;
  localparam logic [3:0]  SRC_NONE     = 4'h0;
  localparam logic [15:0] VEC_RESET    = 16'h0000;
endpackage

// file: ext_sample_if.sv
// Bundle carrying sampled pin events from sampler to request logic
`timescale 1ns/1ps
`default_nettype none
interface ext_sample_if #(parameter int unsigned PINS = 6);
  logic [PINS-1:0] fall;  // One-cycle pulse: high then low sample seen
  logic [PINS-1:0] low;   // Latest machine-cycle sample is low
  modport src (output fall, output low);
  modport dst (input fall, input low);
endinterface
`default_nettype wire

// file: ext_pin_sampler.sv
// Synchronises and samples external request pins once per machine cycle
`timescale 1ns/1ps
`default_nettype none
module ext_pin_sampler
  import irq_pkg::*;
#(
  parameter int unsigned PINS = NUM_PIN,
  parameter int unsigned CLKS = MC_CLKS
)(
  input  wire logic            core_clk,
  input  wire logic            srst,
  input  wire logic [PINS-1:0] pin_n,
  ext_sample_if.src            smp
);
  logic [PINS-1:0] sync1;
  logic [PINS-1:0] sync2;
  logic [PINS-1:0] cur;
  logic [$clog2(CLKS)-1:0] phase;
  logic            tick;

  // Two-flop synchroniser; sync1 feeds only sync2
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sync1 <= '1;
      sync2 <= '1;
    end
    else
    begin
      sync1 <= pin_n;
      sync2 <= sync1;
    end
  end

  // Machine-cycle phase counter
  always_ff @(posedge core_clk)
  begin
    if (srst)
      phase <= '0;
    else if (tick)
      phase <= '0;
    else
      phase <= phase + 1'b1;
  end

  assign tick = (phase == ($clog2(CLKS))'(CLKS - 1));

  // Take one sample per machine cycle; idle level is high
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cur <= '1;
    end
    else if (tick)
    begin
      cur <= sync2;
    end
  end

  // Falling edge: one sample high, the next low
  always_ff @(posedge core_clk)
  begin
    if (srst)
      smp.fall <= '0;
    else
      smp.fall <= tick ? (cur & ~sync2) : '0;
  end

  assign smp.low = ~cur;
endmodule // ext_pin_sampler
`default_nettype wire

// file: ext_irq_logic.sv
// Interrupt request flags, enables, priority and vectoring for 12 sources
//
// Contract
// - Twelve sources, each at one of two levels
// - Each source: own flag, enable, priority, vector
// - Global enable blocks every source
// - Pins a, b select falling edge or low level
// - Edge: high sample then low sets flag
// - Flags a, b timer group; c-f extended group
// - Pins a, b flags cleared on vectoring in edge mode; in level mode the flag follows the pin
// - Level still low after service re-requests
// - Pins c-f falling edge only
// - Flags c-f cleared by software by default
// - Hardware-clear select clears c-f flag on entry
// - Machine cycle is four clocks
`timescale 1ns/1ps
`default_nettype none
module ext_irq_logic
  import irq_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic               ext_req_a_n,
  input  wire logic               ext_req_b_n,
  input  wire logic               ext_req_c_n,
  input  wire logic               ext_req_d_n,
  input  wire logic               ext_req_e_n,
  input  wire logic               ext_req_f_n,
  input  wire logic               trig_type_a,
  input  wire logic               trig_type_b,
  input  wire logic [NUM_HWC-1:0] hw_clear_sel,
  input  wire logic               global_en,
  input  wire logic [NUM_SRC-1:0] src_en,
  input  wire logic [NUM_SRC-1:0] src_prio,
  input  wire logic [NUM_SRC-1:0] periph_set,
  input  wire logic [NUM_SRC-1:0] sw_clear,
  input  wire logic               vector_ack,
  input  wire logic               service_done,
  output logic                    irq_req,
  output logic                    irq_high,
  output logic [SRC_W-1:0]        irq_src,
  output logic [VEC_W-1:0]        irq_vector,
  output logic [1:0]              timer_control_flags,
  output logic [NUM_HWC-1:0]      extended_irq_flags,
  output logic [NUM_SRC-1:0]      req_flags
);
  ext_sample_if #(.PINS(NUM_PIN)) smp ();

  logic [NUM_SRC-1:0] flag;
  logic [NUM_SRC-1:0] next_flag;
  logic [NUM_SRC-1:0] ack_clr;
  logic               serv_hi;
  logic               serv_lo;
  logic               pick_ok;
  logic               pick_hi;
  logic [SRC_W-1:0]   pick_src;
  logic               take;
  wire logic [NUM_HWC-1:0] hwc_hit;

  // Pin sampling at machine-cycle rate
  // Pins are asynchronous; the sampler synchronises them first
  ext_pin_sampler #(
    .PINS (NUM_PIN),
    .CLKS (MC_CLKS)
  ) u_sampler (
    .core_clk (core_clk),
    .srst     (srst),
    .pin_n    ({ext_req_f_n, ext_req_e_n, ext_req_d_n,
                ext_req_c_n, ext_req_b_n, ext_req_a_n}),
    .smp      (smp)
  );

  // Vector taken this cycle
  assign take = vector_ack && irq_req;

  // Hardware-clear hit per pin c..f on vector entry
  for (genvar k = 0; k < NUM_HWC; k++)
  begin : g_hwc
    assign hwc_hit[k] = hw_clear_sel[k]
                      && (irq_src == SRC_W'(SRC_EXT_C + k));
  end : g_hwc

  // Flag clears caused by taking a vector
  always_comb
  begin
    ack_clr = '0;
    if (take)
    begin
      // Pins a and b: cleared on entry; level mode overrides below
      if (irq_src == SRC_W'(SRC_EXT_A))
        ack_clr[SRC_EXT_A] = 1'b1;
      if (irq_src == SRC_W'(SRC_EXT_B))
        ack_clr[SRC_EXT_B] = 1'b1;
      // Pins c..f: left for software unless hardware clear selected
      for (int k = 0; k < NUM_HWC; k++)
        ack_clr[SRC_EXT_C + k] = hwc_hit[k];
    end
  end

  // Next flag values: clears first so a coinciding set wins
  always_comb
  begin
    // Peripheral sets reach only the non-pin slots
    next_flag = (flag & ~ack_clr & ~sw_clear) | (periph_set & ~EXT_MASK);
    // Pin a: edge or level
    if (trig_type_a)
      next_flag[SRC_EXT_A] = next_flag[SRC_EXT_A] | smp.fall[PIN_A];
    else
      next_flag[SRC_EXT_A] = smp.low[PIN_A];
    // Pin b: edge or level
    if (trig_type_b)
      next_flag[SRC_EXT_B] = next_flag[SRC_EXT_B] | smp.fall[PIN_B];
    else
      next_flag[SRC_EXT_B] = smp.low[PIN_B];
    // Pins c..f: edge only
    for (int k = 0; k < NUM_HWC; k++)
      next_flag[SRC_EXT_C + k] = next_flag[SRC_EXT_C + k]
                               | smp.fall[PIN_C + k];
  end

  // Request flag storage, one per source
  always_ff @(posedge core_clk)
  begin
    if (srst)
      flag <= FLAG_RESET;
    else
      flag <= next_flag;
  end

  // Fixed-order pick: high level first, lowest slot wins a tie
  always_comb
  begin
    pick_ok  = 1'b0;
    pick_hi  = 1'b0;
    pick_src = SRC_NONE;
    if (global_en && !serv_hi)
    begin
      // High level; later hits overwrite, so the lowest slot wins
      for (int i = NUM_SRC - 1; i >= 0; i--)
        if (flag[i] && src_en[i] && src_prio[i])
        begin
          pick_ok  = 1'b1;
          pick_hi  = 1'b1;
          pick_src = SRC_W'(i);
        end
      // Low level only with no high request and no low in service
      if (!pick_ok && !serv_lo)
        for (int i = NUM_SRC - 1; i >= 0; i--)
          if (flag[i] && src_en[i] && !src_prio[i])
          begin
            pick_ok  = 1'b1;
            pick_src = SRC_W'(i);
          end
    end
  end

  // Registered request towards the core
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      irq_req    <= 1'b0;
      irq_high   <= 1'b0;
      irq_src    <= SRC_NONE;
      irq_vector <= VEC_RESET;
    end
    else
    begin
      // Drop for one cycle after a take so a vector is taken once
      irq_req    <= pick_ok && !take;
      irq_high   <= pick_hi;
      irq_src    <= pick_src;
      irq_vector <= VEC_W'(VEC_BASE + VEC_STEP * pick_src);
    end
  end

  // In-service tracking per level; completion frees the higher first
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      serv_hi <= 1'b0;
      serv_lo <= 1'b0;
    end
    // A take outranks a completion in the same cycle
    else if (take)
    begin
      if (irq_high)
        serv_hi <= 1'b1;
      else
        serv_lo <= 1'b1;
    end
    else if (service_done)
    begin
      if (serv_hi)
        serv_hi <= 1'b0;
      else
        serv_lo <= 1'b0;
    end
  end

  // Flag views grouped as the two flag registers show them
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      timer_control_flags <= '0;
      extended_irq_flags  <= '0;
      req_flags           <= FLAG_RESET;
    end
    else
    begin
      // Taken from next_flag so the views line up with flag
      timer_control_flags <= {next_flag[SRC_EXT_B],
                              next_flag[SRC_EXT_A]};
      extended_irq_flags  <= next_flag[SRC_EXT_C +: NUM_HWC];
      req_flags           <= next_flag;
    end
  end
endmodule // ext_irq_logic
`default_nettype wire

// file: ext_irq_props.sv
// Checker for the external interrupt request logic
`timescale 1ns/1ps
`default_nettype none
module ext_irq_props
  import irq_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        ext_req_a_n,
  input wire logic        ext_req_b_n,
  input wire logic        trig_type_a,
  input wire logic        trig_type_b,
  input wire logic [3:0]  hw_clear_sel,
  input wire logic        global_en,
  input wire logic [11:0] periph_set,
  input wire logic [11:0] sw_clear,
  input wire logic        vector_ack,
  input wire logic        irq_req,
  input wire logic        irq_high,
  input wire logic [3:0]  irq_src,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0]  timer_control_flags,
  input wire logic [3:0]  extended_irq_flags,
  input wire logic [11:0] req_flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  // Request, vector and flag relations
  a_ack_drops_req: assert property (
    vector_ack && irq_req |=> !irq_req)
    else $error("request held after ack");
  a_vec_of_src: assert property (irq_req |->
    irq_vector == VEC_BASE + VEC_STEP * irq_src) else $error("bad vector");
  a_timer_group: assert property (
    timer_control_flags == {req_flags[2], req_flags[0]})
    else $error("timer flag group off");
  a_ext_group: assert property (
    extended_irq_flags == req_flags[10:7])
    else $error("extended flag group off");
  a_global_off: assert property (!global_en [*2] |-> !irq_req)
    else $error("request while disabled");
  a_edge_sets: assert property ($fell(ext_req_a_n) && trig_type_a
    |-> ##[1:10] req_flags[0]) else $error("edge missed");
  a_level_low: assert property (
    (!trig_type_b && !ext_req_b_n) [*8] |=> req_flags[2])
    else $error("level flag not set");
  a_level_high: assert property (
    (!trig_type_b && ext_req_b_n) [*8] |=> !req_flags[2])
    else $error("level flag not cleared");
  a_hw_clear: assert property (
    vector_ack && irq_req && irq_src == 4'h7
    && hw_clear_sel[0] |=> !req_flags[7]) else $error("no hw clear");
  a_sw_keeps: assert property (
    vector_ack && irq_req && irq_src == 4'h7
    && !hw_clear_sel[0] && !sw_clear[7] |=> req_flags[7])
    else $error("flag lost on ack");
  a_periph_set: assert property (periph_set[1] |=> req_flags[1])
    else $error("set pulse lost");

  // Main scenarios
  c_high: cover property (vector_ack && irq_req && irq_high);
  c_level: cover property (!trig_type_b && irq_req && irq_src == 4'h2);
  c_ext: cover property (irq_req && irq_src == 4'h9);
endmodule // ext_irq_props
bind ext_irq_logic ext_irq_props ext_irq_props_i (
  .core_clk            (core_clk),
  .srst                (srst),
  .ext_req_a_n         (ext_req_a_n),
  .ext_req_b_n         (ext_req_b_n),
  .trig_type_a         (trig_type_a),
  .trig_type_b         (trig_type_b),
  .hw_clear_sel        (hw_clear_sel),
  .global_en           (global_en),
  .periph_set          (periph_set),
  .sw_clear            (sw_clear),
  .vector_ack          (vector_ack),
  .irq_req             (irq_req),
  .irq_high            (irq_high),
  .irq_src             (irq_src),
  .irq_vector          (irq_vector),
  .timer_control_flags (timer_control_flags),
  .extended_irq_flags  (extended_irq_flags),
  .req_flags           (req_flags)
);
`default_nettype wire

// file: ext_src_model.sv
// External circuitry driving the request pins
`timescale 1ns/1ps
`default_nettype none
module ext_src_model
(
  input  wire logic       core_clk,
  output logic      [5:0] pin_n
);
  // Idle at the pull-up level
  initial pin_n = 6'h3f;

  // Hold high, fall, hold low, release to pull-up
  task automatic drop(input int k, input int low_cyc);
    repeat (8) @(posedge core_clk);
    #1 pin_n[k] = 1'b0;
    repeat (low_cyc) @(posedge core_clk);
    #1 pin_n[k] = 1'b1;
  endtask
endmodule // ext_src_model
`default_nettype wire

// file: tb_ext_irq_logic.sv
// Self-checking bench for the external interrupt request logic
`timescale 1ns/1ps
`default_nettype none
module tb_ext_irq_logic
  import irq_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        trig_type_a, trig_type_b, global_en, vector_ack;
  logic        service_done, irq_req, irq_high, prev_req;
  logic [5:0]  pin_n;
  logic [3:0]  hw_clear_sel, irq_src, eif, s, sl;
  logic [11:0] src_en, src_prio, periph_set, sw_clear, req_flags;
  logic [15:0] irq_vector;
  logic [1:0]  tcf;
  logic [3:0]  exp_q[$];
  int          bad_count = 0, checks = 0, seed = 58;

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  ext_src_model ext_src_model_i (.core_clk(core_clk), .pin_n(pin_n));
  ext_irq_logic ext_irq_logic_i (.core_clk(core_clk), .srst(srst),
    .ext_req_a_n(pin_n[0]), .ext_req_b_n(pin_n[1]), .ext_req_c_n(pin_n[2]),
    .ext_req_d_n(pin_n[3]), .ext_req_e_n(pin_n[4]), .ext_req_f_n(pin_n[5]),
    .trig_type_a(trig_type_a), .trig_type_b(trig_type_b),
    .hw_clear_sel(hw_clear_sel), .global_en(global_en), .src_en(src_en),
    .src_prio(src_prio), .periph_set(periph_set), .sw_clear(sw_clear),
    .vector_ack(vector_ack), .service_done(service_done),
    .irq_req(irq_req), .irq_high(irq_high), .irq_src(irq_src),
    .irq_vector(irq_vector), .timer_control_flags(tcf),
    .extended_irq_flags(eif), .req_flags(req_flags));

  task automatic check(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Wait for a request, take its vector, check flag, clear in software
  task automatic serve(input logic [3:0] f, input logic fl);
    logic [11:0] oh;
    oh = 12'h001 << f;
    for (int n = 0; n < 60 && irq_req !== 1'b1; n++)
      tick(1);
    check("request", irq_req, 1'b1);
    check("flag groups", {eif, tcf}, {oh[10:7], oh[2], oh[0]});
    vector_ack = 1'b1;
    tick(1);
    vector_ack = 1'b0;
    check("flag", req_flags[f], fl);
    sw_clear[f] = 1'b1;
    tick(1);
    sw_clear = '0;
  endtask

  task automatic done_svc;
    service_done = 1'b1;
    tick(1);
    service_done = 1'b0;
  endtask

  // Compare each new request with the oldest note, away from the edge
  always @(negedge core_clk)
  begin
    prev_req <= irq_req;
    if (!srst && irq_req === 1'b1 && prev_req !== 1'b1)
    begin
      s = exp_q.size() > 0 ? exp_q.pop_front() : 4'hf;
      check("source", irq_src, s);
      check("vector", irq_vector, VEC_BASE + VEC_STEP * s);
      check("level", irq_high, src_prio[s]);
    end
  end

  // Main sequence
  initial
  begin
    {trig_type_a, trig_type_b, global_en} = 3'h7;
    {vector_ack, service_done} = 2'h0;
    src_en = 12'hfff;
    src_prio = '0;
    periph_set = '0;
    sw_clear = '0;
    hw_clear_sel = 4'($random(seed));
    tick(20);
    srst = 1'b0;
    // Second pass inverts the hardware-clear selects
    repeat (2)
    begin
      for (int k = 0; k < 6; k++)
      begin
        sl = k < 2 ? 4'(2 * k) : 4'(k + 5);
        exp_q.push_back(sl);
        fork
          ext_src_model_i.drop(k, 8);
          serve(sl, k < 2 ? 1'b0 : !hw_clear_sel[2'(k - 2)]);
        join
        done_svc();
      end
      hw_clear_sel = ~hw_clear_sel;
    end
    $display("pin edge test done");
    src_prio[5] = 1'($random(seed));
    sl = src_prio[5] ? 4'h5 : 4'h3;
    exp_q.push_back(sl);
    exp_q.push_back(sl ^ 4'h6);
    periph_set = 12'h0028;
    tick(1);
    periph_set = '0;
    serve(sl, 1'b1);
    done_svc();
    serve(sl ^ 4'h6, 1'b1);
    done_svc();
    $display("priority test done");
    global_en = 1'b0;
    periph_set[1] = 1'b1;
    tick(1);
    periph_set = '0;
    tick(12);
    check("blocked", irq_req, 1'b0);
    {global_en, src_en[1]} = 2'b10;
    tick(12);
    check("masked", irq_req, 1'b0);
    exp_q.push_back(4'h1);
    src_en[1] = 1'b1;
    serve(4'h1, 1'b1);
    done_svc();
    $display("global enable test done");
    trig_type_b = 1'b0;
    exp_q.push_back(4'h2);
    exp_q.push_back(4'h2);
    fork
      ext_src_model_i.drop(1, 24);
      begin
        serve(4'h2, 1'b1);
        done_svc();
        serve(4'h2, 1'b1);
      end
    join
    tick(12);
    check("level flag", req_flags[2], 1'b0);
    done_svc();
    tick(4);
    check("notes left", 16'(exp_q.size()), 16'h0000);
    $display("level test done");
    final_report();
  end

  // Cut a hang short
  initial
  begin
    tick(3000);
    bad_count++;
    final_report();
  end
endmodule // tb_ext_irq_logic
`default_nettype wire
